/* File: verilog/pllcm_top.sv */
// pll clock module: register file on apb, mode control, clock selection
// assumes mclk is the oscillator clock; ref pins arrive unsynchronised
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module pllcm_top
  import pllcm_pkg::*;
#(
  parameter int LOCK_CYCLES = PLLCM_LOCK_OSC_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        crystal_in_pin,
  input  wire logic        ext_clock_pin,
  input  wire logic        pll_clk,
  input  wire logic        limp_clk,
  output logic      [3:0]  pll_mult,
  output logic             pll_enable,
  output logic             cpu_clock_in,
  output logic             system_clock_out,
  output logic             cpu_reset_req,
  output logic             irq
);

  logic [15:0] clkout_reg, pclk2_reg, fastp_reg, slowp_reg;
  logic [15:0] pclk0_reg, pclk1_reg, lpm0_reg, sysc_reg;
  logic [15:0] wdcnt_reg, watchdog_key_reg, wdctl_reg;
  logic [3:0]  ratio_reg;
  logic        halving_reg, pwrdown_reg, missing_reg, permit_reg;
  logic [PLLCM_IRQ_W-1:0] irq_stat_reg, irq_mask_reg;
  logic [PLLCM_CNT_W-1:0] lock_cnt_reg;
  pllcm_mode_t mode_reg;
  logic [1:0]  xtal_sync, ext_sync, pll_sync, limp_sync;
  logic        ref_prev_reg, limp_prev_reg;
  logic [4:0]  miss_cnt_reg;
  logic        div2_reg, sel_mult_reg, sel_raw_reg;

  logic [15:0] idx;
  logic        wr_en, wr_ok, hit;
  logic        ratio_wr, lock_done, ref_lvl, ref_edge, limp_edge;
  logic [31:0] rdata_next;

  // apb decode: zero-wait slave, word index from byte address
  assign idx      = paddr[17:2];
  assign wr_en    = psel && penable && pwrite && clk_en;
  assign pready   = 1'b1;
  assign wr_ok    = wr_en && (permit_reg || idx == PLLCM_IDX_PERMIT);
  assign ratio_wr = wr_ok && idx == PLLCM_IDX_PLL_RATIO;
  assign lock_done = mode_reg == PLLCM_LOCKING &&
                     lock_cnt_reg == PLLCM_CNT_W'(LOCK_CYCLES - 1);

  // read mux; unmapped addresses flag pslverr
  always_comb begin
    rdata_next = 32'h0000_0000;
    hit = 1'b1;
    case (idx)
      PLLCM_IDX_CLKOUT_CTRL: rdata_next = {16'h0, clkout_reg};
      PLLCM_IDX_PLL_STATE:   rdata_next = {28'h0, missing_reg, pwrdown_reg,
                                           halving_reg,
                                           mode_reg == PLLCM_ENABLED};
      PLLCM_IDX_PCLK_CTRL2:  rdata_next = {16'h0, pclk2_reg};
      PLLCM_IDX_FAST_PRESC:  rdata_next = {16'h0, fastp_reg};
      PLLCM_IDX_SLOW_PRESC:  rdata_next = {16'h0, slowp_reg};
      PLLCM_IDX_PCLK_CTRL0:  rdata_next = {16'h0, pclk0_reg};
      PLLCM_IDX_PCLK_CTRL1:  rdata_next = {16'h0, pclk1_reg};
      PLLCM_IDX_LPM_CTRL0:   rdata_next = {16'h0, lpm0_reg};
      PLLCM_IDX_PLL_RATIO:   rdata_next = {28'h0, ratio_reg};
      PLLCM_IDX_SYS_CTRL:    rdata_next = {16'h0, sysc_reg};
      PLLCM_IDX_WD_COUNT:    rdata_next = {16'h0, wdcnt_reg};
      PLLCM_IDX_WD_KEY:      rdata_next = {16'h0, watchdog_key_reg};
      PLLCM_IDX_WD_CTRL:     rdata_next = {16'h0, wdctl_reg};
      PLLCM_IDX_PERMIT:      rdata_next = {31'h0, permit_reg};
      PLLCM_IDX_IRQ_STATUS:  rdata_next = {30'h0, irq_stat_reg};
      PLLCM_IDX_IRQ_MASK:    rdata_next = {30'h0, irq_mask_reg};
      default:               hit = 1'b0;
    endcase
  end

  // registered read data and error
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata  <= rdata_next;
        pslverr <= !hit;
      end
    end
  end

  // protected write permit, itself always writable
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      permit_reg <= 1'b0;
    end else if (wr_en && idx == PLLCM_IDX_PERMIT) begin
      permit_reg <= pwdata[0];
    end
  end

  // plain storage registers of the block
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clkout_reg <= 16'h0000;
      pclk2_reg  <= 16'h0000;
      fastp_reg  <= 16'h0000;
      slowp_reg  <= 16'h0000;
      pclk0_reg  <= 16'h0000;
      pclk1_reg  <= 16'h0000;
      lpm0_reg   <= 16'h0000;
      sysc_reg   <= 16'h0000;
      wdcnt_reg  <= 16'h0000;
      watchdog_key_reg  <= 16'h0000;
      wdctl_reg  <= 16'h0000;
    end else if (wr_ok) begin
      case (idx)
        PLLCM_IDX_CLKOUT_CTRL: clkout_reg <= pwdata[15:0];
        PLLCM_IDX_PCLK_CTRL2:  pclk2_reg  <= pwdata[15:0];
        PLLCM_IDX_FAST_PRESC:  fastp_reg  <= pwdata[15:0];
        PLLCM_IDX_SLOW_PRESC:  slowp_reg  <= pwdata[15:0];
        PLLCM_IDX_PCLK_CTRL0:  pclk0_reg  <= pwdata[15:0];
        PLLCM_IDX_PCLK_CTRL1:  pclk1_reg  <= pwdata[15:0];
        PLLCM_IDX_LPM_CTRL0:   lpm0_reg   <= pwdata[15:0];
        PLLCM_IDX_SYS_CTRL:    sysc_reg   <= pwdata[15:0];
        PLLCM_IDX_WD_KEY:      watchdog_key_reg  <= pwdata[15:0];
        PLLCM_IDX_WD_CTRL:     wdctl_reg  <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ratio field; halving and power-down in the status register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ratio_reg   <= PLLCM_RATIO_BYPASS;
      halving_reg <= 1'b0;
      pwrdown_reg <= 1'b0;
    end else if (clk_en) begin
      if (ratio_wr) begin
        ratio_reg <= pwdata[3:0];
      end
      if (wr_ok && idx == PLLCM_IDX_PLL_STATE) begin
        // halving only honoured while the ratio is all zero
        if (ratio_reg == PLLCM_RATIO_BYPASS) begin
          halving_reg <= pwdata[PLLCM_ST_HALVING];
        end
        pwrdown_reg <= pwdata[PLLCM_ST_PWRDOWN];
      end
    end
  end

  // mode machine with lock counter
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_reg     <= PLLCM_BYPASS;
      lock_cnt_reg <= '0;
    end else if (clk_en) begin
      case (mode_reg)
        PLLCM_BYPASS, PLLCM_ENABLED: begin
          if (pwrdown_reg) begin
            mode_reg <= PLLCM_OFF;
          end else if (ratio_wr) begin
            mode_reg     <= PLLCM_LOCKING;
            lock_cnt_reg <= '0;
          end
        end
        PLLCM_LOCKING: begin
          lock_cnt_reg <= lock_cnt_reg + 1'b1;
          if (pwrdown_reg) begin
            mode_reg <= PLLCM_OFF;
          end else if (ratio_wr) begin
            lock_cnt_reg <= '0;
          end else if (lock_done) begin
            // reserved or zero codes stay in bypass
            if (ratio_reg != PLLCM_RATIO_BYPASS &&
                ratio_reg <= PLLCM_RATIO_MAX) begin
              mode_reg <= PLLCM_ENABLED;
            end else begin
              mode_reg <= PLLCM_BYPASS;
            end
          end
        end
        PLLCM_OFF: begin
          if (!pwrdown_reg) begin
            mode_reg     <= PLLCM_LOCKING;
            lock_cnt_reg <= '0;
          end
        end
        default: mode_reg <= PLLCM_BYPASS;
      endcase
    end
  end

  // pin and clock samples through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      xtal_sync <= 2'b00;
      ext_sync  <= 2'b00;
      pll_sync  <= 2'b00;
      limp_sync <= 2'b00;
    end else if (clk_en) begin
      xtal_sync <= {xtal_sync[0], crystal_in_pin};
      ext_sync  <= {ext_sync[0], ext_clock_pin};
      pll_sync  <= {pll_sync[0], pll_clk};
      limp_sync <= {limp_sync[0], limp_clk};
    end
  end

  // reference source: crystal, or ext pin when clkout_reg bit PLLCM_XC_SRC_EXT is set
  assign ref_lvl = clkout_reg[PLLCM_XC_SRC_EXT] ? ext_sync[1]
                                                : xtal_sync[1];
  assign ref_edge  = ref_lvl != ref_prev_reg;
  assign limp_edge = limp_sync[1] != limp_prev_reg;

  // missing ref watch: count limp edges with no ref edge between
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ref_prev_reg  <= 1'b0;
      limp_prev_reg <= 1'b0;
      miss_cnt_reg  <= 5'h00;
      missing_reg   <= 1'b0;
    end else if (clk_en) begin
      ref_prev_reg  <= ref_lvl;
      limp_prev_reg <= limp_sync[1];
      if (ref_edge || mode_reg == PLLCM_OFF) begin
        miss_cnt_reg <= 5'h00;
      end else if (limp_edge &&
                   miss_cnt_reg != 5'(PLLCM_MISSING_CYCLES)) begin
        miss_cnt_reg <= miss_cnt_reg + 1'b1;
      end
      if (miss_cnt_reg == 5'(PLLCM_MISSING_CYCLES)) begin
        missing_reg <= 1'b1;
      end else if (wr_ok && idx == PLLCM_IDX_PLL_STATE &&
                   pwdata[PLLCM_ST_MISSING]) begin
        missing_reg <= 1'b0;
      end
    end
  end
  assign cpu_reset_req = missing_reg;

  // halver and glitch-free select, updated only on edges where the divider is high
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div2_reg     <= 1'b0;
      sel_mult_reg <= 1'b0;
      sel_raw_reg  <= 1'b0;
    end else if (clk_en) begin
      div2_reg <= !div2_reg;
      if (div2_reg) begin
        sel_mult_reg <= mode_reg == PLLCM_ENABLED;
        sel_raw_reg  <= halving_reg;
      end
    end
  end

  // clock mux: multiplied, limp, or bypass (halved or raw)
  always_comb begin
    if (missing_reg) begin
      cpu_clock_in = limp_sync[1];
    end else if (sel_mult_reg) begin
      cpu_clock_in = pll_sync[1];
    end else if (sel_raw_reg) begin
      cpu_clock_in = mclk;
    end else begin
      cpu_clock_in = div2_reg;
    end
  end
  assign system_clock_out = cpu_clock_in;
  assign pll_mult   = mode_reg == PLLCM_OFF ? 4'h0 : ratio_reg;
  assign pll_enable = mode_reg != PLLCM_OFF;

  // sticky interrupts: lock reached, ref missing; write one clears
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else if (clk_en) begin
      if (wr_ok && idx == PLLCM_IDX_IRQ_MASK) begin
        irq_mask_reg <= pwdata[PLLCM_IRQ_W-1:0];
      end
      irq_stat_reg <= (irq_stat_reg &
                       ~((wr_ok && idx == PLLCM_IDX_IRQ_STATUS) ?
                         pwdata[PLLCM_IRQ_W-1:0] : '0))
                      | {miss_cnt_reg == 5'(PLLCM_MISSING_CYCLES),
                         lock_done};
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule

`default_nettype wire

/* File: common/pllcm_pkg.sv */
// package for the pll clock module: register map, fields, timing counts
// assumes an apb slave view with 32-bit data, one register per word
package pllcm_pkg;

  // printed offsets are word indices; byte address is four times the index
  localparam logic [15:0] PLLCM_IDX_CLKOUT_CTRL  = 16'h7010;
  localparam logic [15:0] PLLCM_IDX_PLL_STATE    = 16'h7011;
  localparam logic [15:0] PLLCM_IDX_PCLK_CTRL2   = 16'h7019;
  localparam logic [15:0] PLLCM_IDX_FAST_PRESC   = 16'h701a;
  localparam logic [15:0] PLLCM_IDX_SLOW_PRESC   = 16'h701b;
  localparam logic [15:0] PLLCM_IDX_PCLK_CTRL0   = 16'h701c;
  localparam logic [15:0] PLLCM_IDX_PCLK_CTRL1   = 16'h701d;
  localparam logic [15:0] PLLCM_IDX_LPM_CTRL0    = 16'h701e;
  localparam logic [15:0] PLLCM_IDX_PLL_RATIO    = 16'h7021;
  localparam logic [15:0] PLLCM_IDX_SYS_CTRL     = 16'h7022;
  localparam logic [15:0] PLLCM_IDX_WD_COUNT     = 16'h7023;
  localparam logic [15:0] PLLCM_IDX_WD_KEY       = 16'h7025;
  localparam logic [15:0] PLLCM_IDX_WD_CTRL      = 16'h7029;
  // own registers: write permit, interrupt status and mask
  localparam logic [15:0] PLLCM_IDX_PERMIT       = 16'h7030;
  localparam logic [15:0] PLLCM_IDX_IRQ_STATUS   = 16'h7031;
  localparam logic [15:0] PLLCM_IDX_IRQ_MASK     = 16'h7032;

  localparam int PLLCM_ADDR_W = 18;

  // pll_status_register fields
  localparam int PLLCM_ST_LOCKED   = 0;
  localparam int PLLCM_ST_HALVING  = 1;
  localparam int PLLCM_ST_PWRDOWN  = 2;
  localparam int PLLCM_ST_MISSING  = 3;
  // clkout_pin_ctrl_status field: reference source select
  localparam int PLLCM_XC_SRC_EXT  = 0;
  localparam int PLLCM_XC_EXTMODE  = 1;
  // interrupt bits
  localparam int PLLCM_IRQ_LOCK    = 0;
  localparam int PLLCM_IRQ_MISSING = 1;
  localparam int PLLCM_IRQ_W       = 2;

  localparam logic [3:0] PLLCM_RATIO_BYPASS = 4'h0;
  localparam logic [3:0] PLLCM_RATIO_MAX    = 4'ha;

  // timing
  localparam int PLLCM_CLK_HZ          = 20000000;
  localparam int PLLCM_LOCK_OSC_CYCLES = 131072;
  localparam int PLLCM_MISSING_CYCLES  = 16;
  localparam int PLLCM_CNT_W           = 18;

  typedef enum logic [1:0] {
    PLLCM_BYPASS,
    PLLCM_LOCKING,
    PLLCM_ENABLED,
    PLLCM_OFF
  } pllcm_mode_t;

endpackage

/* File: verif/pllcm_osc_model.sv */
// oscillator side model: crystal reference, analog pll and limp clocks
// assumes mclk stands for the oscillator; ref_stop removes the reference
`timescale 1ns/1ns
`default_nettype none
module pllcm_osc_model (
  input  wire logic mclk,
  input  wire logic ref_stop,
  output logic      crystal_in_pin,
  output logic      ext_clock_pin,
  output logic      pll_clk,
  output logic      limp_clk
);
  logic [3:0] div_reg = 4'h0;
  // free running divider behind every derived clock
  always @(posedge mclk) div_reg <= div_reg + 4'h1;
  // crystal feeds the reference; the unused external pin is tied low
  assign crystal_in_pin = ref_stop ? 1'b0 : div_reg[1];
  assign ext_clock_pin  = 1'b0;
  // pll output and limp oscillator keep running when the reference stops
  assign pll_clk  = div_reg[2];
  assign limp_clk = div_reg[3];
endmodule
`default_nettype wire

/* File: verif/pllcm_top_asserts.sv */
// checker for pllcm_top: apb answer, ratio, power-down, clock echo
// assumes the write permit resets to zero and is bit0 of its register
`timescale 1ns/1ns
`default_nettype none
module pllcm_checker
  import pllcm_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [3:0]  pll_mult,
  input wire logic        pll_enable,
  input wire logic        cpu_clock_in,
  input wire logic        system_clock_out
);
  logic wr_acc;
  logic wr_rat;
  logic ok_rat;
  logic permit_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // write strobes seen on the bus
  assign wr_acc = psel && penable && pwrite && clk_en;
  assign wr_rat = wr_acc && paddr == {PLLCM_IDX_PLL_RATIO, 2'b00};
  assign ok_rat = wr_rat && permit_reg && pll_enable;
  // mirror of the write permit as software sets it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst)
      permit_reg <= 1'b0;
    else if (wr_acc && paddr == {PLLCM_IDX_PERMIT, 2'b00})
      permit_reg <= pwdata[0];
  end
  property p_echo; cpu_clock_in == system_clock_out; endproperty
  a_echo: assert property (p_echo) else $error("clock echo differs");
  property p_rst; $rose(nrst) |-> pll_mult == 4'h0 && pll_enable; endproperty
  a_rst: assert property (p_rst) else $error("not bypass at reset");
  property p_off; !pll_enable |-> pll_mult == 4'h0; endproperty
  a_off: assert property (p_off) else $error("ratio out while off");
  property p_rat; ok_rat && pwdata[3:0] inside {[4'h1:4'ha]}
    |=> pll_mult == $past(pwdata[3:0]); endproperty
  a_rat: assert property (p_rat) else $error("ratio not applied");
  property p_zero; ok_rat && pwdata[3:0] == 4'h0
    |=> pll_mult == 4'h0 ##1 pll_enable; endproperty
  a_zero: assert property (p_zero) else $error("bypass stopped pll");
  property p_keep; wr_rat && !permit_reg |=> $stable(pll_mult); endproperty
  a_keep: assert property (p_keep) else $error("locked write taken");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_idle; !(psel && penable) |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
endmodule
bind pllcm_top pllcm_checker i_pllcm_checker (
  .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .pll_mult(pll_mult),
  .pll_enable(pll_enable), .cpu_clock_in(cpu_clock_in),
  .system_clock_out(system_clock_out)
);
`default_nettype wire

/* File: verif/testbench.sv */
// testbench for pllcm_top: apb master, oscillator model, scenario tasks
// assumes a 20 mhz mclk and a lock count shortened to 16 cycles
`timescale 1ns/1ns
`default_nettype none
module testbench
  import pllcm_pkg::*;
;
  localparam int          LOCK = 16;
  localparam logic [15:0] RAT  = PLLCM_IDX_PLL_RATIO;
  localparam logic [15:0] STS  = PLLCM_IDX_PLL_STATE;
  localparam logic [15:0] IST  = PLLCM_IDX_IRQ_STATUS;
  localparam logic [15:0] IMK  = PLLCM_IDX_IRQ_MASK;
  logic        mclk = 1'b0, nrst = 1'b0, ref_stop = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic        pready, pslverr, errv, xtal, clkout_pin_ctrl_status, pclk, lclk;
  logic [3:0]  pll_mult;
  logic        pll_enable, cpu_clk, sys_clk, rst_req, irq;
  int          num_errors = 0, checked = 0, cyc = 0;
  // 50 ns clock and a cycle count
  always #25 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  pllcm_top #(.LOCK_CYCLES(LOCK)) i_pllcm_top (
    .mclk(mclk), .nrst(nrst), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_in_pin(xtal), .ext_clock_pin(clkout_pin_ctrl_status), .pll_clk(pclk),
    .limp_clk(lclk), .pll_mult(pll_mult), .pll_enable(pll_enable),
    .cpu_clock_in(cpu_clk), .system_clock_out(sys_clk),
    .cpu_reset_req(rst_req), .irq(irq));
  pllcm_osc_model i_pllcm_osc_model (.mclk(mclk), .ref_stop(ref_stop),
    .crystal_in_pin(xtal), .ext_clock_pin(clkout_pin_ctrl_status), .pll_clk(pclk),
    .limp_clk(lclk));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // verdict and end of run
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer held until pready, then one idle cycle
  task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    if (n >= 20) begin
      num_errors++;
      final_report;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // status bit polled until it reads v, bounded
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, STS, 32'h0);
      n++;
    end while (rdv[b] !== v && n < 400);
    chk("poll", {31'h0, rdv[b]}, {31'h0, v});
    if (n >= 400)
      final_report;
  endtask
  // cpu clock changes seen just after each of n rising edges
  task automatic toggles(input int n, output int t);
    logic p;
    t = 0;
    #1 p = cpu_clk;
    repeat (n) begin
      @(posedge mclk);
      #1;
      t += int'(cpu_clk !== p);
      p = cpu_clk;
    end
    @(posedge mclk);
  endtask
  // reset state and the halved bypass clock
  task automatic t_reset;
    int t;
    apb(1'b0, RAT, 32'h0);
    chk("ratio", rdv, 32'h0);
    apb(1'b0, STS, 32'h0);
    chk("halve_off", {29'h0, rdv[2:0]}, 32'h0);
    toggles(20, t);
    chk("div2", t, 20);
  endtask
  // refused write without permit, unmapped read, then permit set
  task automatic t_permit;
    apb(1'b1, RAT, 32'h5);
    apb(1'b0, RAT, 32'h0);
    chk("refused", {rdv[27:0], pll_mult}, 32'h0);
    apb(1'b0, 16'h7012, 32'h0);
    chk("unmapped", {31'h0, errv}, 32'h1);
    apb(1'b1, PLLCM_IDX_PERMIT, 32'h1);
  endtask
  // ratio write, lock time, lock interrupt, relock, reserved code
  task automatic t_ratio;
    int t;
    int k;
    apb(1'b1, IMK, 32'h1);
    apb(1'b1, IST, 32'h3);
    apb(1'b1, RAT, 32'h5);
    t = cyc;
    chk("mult", {28'h0, pll_mult}, 32'h5);
    apb(1'b0, STS, 32'h0);
    chk("bypass_first", {31'h0, rdv[PLLCM_ST_LOCKED]}, 32'h0);
    poll(PLLCM_ST_LOCKED, 1'b1);
    chk("lock_time", {31'h0, (cyc - t >= LOCK)}, 32'h1);
    toggles(16, k);
    chk("mult_clk", k, 4);
    chk("irq_lock", {31'h0, irq}, 32'h1);
    apb(1'b1, IMK, 32'h0);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    apb(1'b1, IST, 32'h1);
    apb(1'b1, IMK, 32'h1);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    apb(1'b1, RAT, 32'hb);
    apb(1'b0, STS, 32'h0);
    chk("relock", {31'h0, rdv[PLLCM_ST_LOCKED]}, 32'h0);
    repeat (LOCK + 8) @(posedge mclk);
    apb(1'b0, STS, 32'h0);
    chk("reserved", {31'h0, rdv[PLLCM_ST_LOCKED]}, 32'h0);
  endtask
  // halving accepted only with the ratio at zero, then power-down
  task automatic t_halve;
    int k;
    apb(1'b1, RAT, 32'h3);
    apb(1'b1, STS, 32'h2);
    apb(1'b0, STS, 32'h0);
    chk("halve_no", {31'h0, rdv[PLLCM_ST_HALVING]}, 32'h0);
    apb(1'b1, RAT, 32'h0);
    apb(1'b1, STS, 32'h2);
    apb(1'b0, STS, 32'h0);
    chk("halve_yes", {31'h0, rdv[PLLCM_ST_HALVING]}, 32'h1);
    toggles(8, k);
    chk("raw_clk", k, 0);
    apb(1'b1, STS, 32'h4);
    @(posedge mclk);
    chk("pll_off", {27'h0, pll_enable, pll_mult}, 32'h0);
    apb(1'b1, STS, 32'h0);
    @(posedge mclk);
    chk("pll_on", {31'h0, pll_enable}, 32'h1);
  endtask
  // reference removed: missing flag, reset request, interrupt, clear
  task automatic t_missing;
    apb(1'b1, IMK, 32'h2);
    ref_stop <= 1'b1;
    poll(PLLCM_ST_MISSING, 1'b1);
    chk("req", {30'h0, rst_req, irq}, 32'h3);
    ref_stop <= 1'b0;
    // let the reference edges reach the watch before clearing
    repeat (8) @(posedge mclk);
    apb(1'b1, STS, 32'h8);
    apb(1'b1, IST, 32'h3);
    chk("req_clr", {30'h0, rst_req, irq}, 32'h0);
  endtask
  // reset, then the scenarios in order
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_permit;
    t_ratio;
    t_halve;
    t_missing;
    final_report;
  end
endmodule
`default_nettype wire
